// file: sram_host_cfg.svh
`ifndef SRAM_HOST_CFG_SVH
`define SRAM_HOST_CFG_SVH
// address and data widths of the memory
`define SRAM_ADDR_W 20
`define SRAM_DATA_W 16
// x8 mode adds one address bit on the top data pin
`define SRAM_BYTE_ADDR_W 21
// top data pin index, doubles as extra address bit in x8 mode
`define SRAM_TOP_PIN 15
// clock period in ns
`define SRAM_CLK_NS 40
// read access time in ns, rounded up to cycles
`define SRAM_ACCESS_NS 55
`define SRAM_ACCESS_CYC ((`SRAM_ACCESS_NS + `SRAM_CLK_NS - 1) / `SRAM_CLK_NS)
// write strobe low time in ns, rounded up to cycles
`define SRAM_WRITE_NS 45
`define SRAM_WRITE_CYC ((`SRAM_WRITE_NS + `SRAM_CLK_NS - 1) / `SRAM_CLK_NS)
// state codes, one-hot
`define ST_IDLE 6'h01
`define ST_RSET 6'h02
`define ST_RWAIT 6'h04
`define ST_WSET 6'h08
`define ST_WPULSE 6'h10
`define ST_DONE 6'h20
`endif

// file: sram_host_pkg.sv
`include "sram_host_cfg.svh"
package sram_host_pkg;
  // access sequencer states
  typedef enum logic [5:0] {
    ST_IDLE = `ST_IDLE,
    ST_RSET = `ST_RSET,
    ST_RWAIT = `ST_RWAIT,
    ST_WSET = `ST_WSET,
    ST_WPULSE = `ST_WPULSE,
    ST_DONE = `ST_DONE
  } access_state_e;
endpackage : sram_host_pkg

// file: sram_sync2.sv
`timescale 1ns/1ns
// two-stage synchroniser for data pins coming back from the memory
module sram_sync2 #(
  parameter int WIDTH = 16
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  // first stage, read only by the second
  logic [WIDTH-1:0] meta;

  // both stages clear on reset
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule : sram_sync2

// file: sram_host.sv
`timescale 1ns/1ns
`include "sram_host_cfg.svh"
// How it works
// - write: selected with write strobe low
// - read: selected with write strobe high
// - host drives no data pin during wide reads; x8 reads drive only the top pin
// - width select static, sampled when idle
module sram_host #(
  parameter int ACCESS_CYC = `SRAM_ACCESS_CYC,
  parameter int WRITE_CYC = `SRAM_WRITE_CYC
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic i_req_write,
  input wire logic [`SRAM_BYTE_ADDR_W-1:0] i_req_addr,
  input wire logic [`SRAM_DATA_W-1:0] i_req_wdata,
  input wire logic [1:0] i_req_lanes,
  input wire logic i_wide_mode,
  output logic o_resp_valid,
  output logic [`SRAM_DATA_W-1:0] o_resp_rdata,
  output logic [`SRAM_ADDR_W-1:0] o_mem_addr,
  output logic o_chip_select_low_n,
  output logic o_chip_select_high,
  output logic o_write_strobe_n,
  output logic o_output_gate_n,
  output logic o_low_lane_select_n,
  output logic o_high_lane_select_n,
  output logic o_width_select,
  input wire logic [`SRAM_DATA_W-1:0] i_data_pin,
  output logic [`SRAM_DATA_W-1:0] o_data_pin,
  output logic [`SRAM_DATA_W-1:0] o_data_pin_oe
);
  ////////////////////////////////////////////////////////////////////////////
  // state and access registers
  sram_host_pkg::access_state_e state; // sequencer state
  logic [7:0] wait_cnt; // cycles left in current phase
  logic is_write; // latched direction
  logic [1:0] lanes; // latched lane enables, bit0 low byte
  logic [`SRAM_DATA_W-1:0] wdata; // latched write data
  logic [`SRAM_DATA_W-1:0] rdata_sync; // data pins after two flops
  logic wide; // width mode, latched only when idle
  logic x8_top; // extra address bit for x8 mode

  // read data passes two flops before use
  sram_sync2 #(.WIDTH(`SRAM_DATA_W)) u_sync (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_async(i_data_pin),
    .o_sync(rdata_sync)
  );

  // ready only while idle, so no request slips in mid-access
  assign o_req_ready = (state == sram_host_pkg::ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // width mode: a static strap, only resampled in idle cycles with no request
  // so the width used to capture a request is the one used for its whole access
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      wide <= 1'b1;
    end else if (state == sram_host_pkg::ST_IDLE && !i_req_valid) begin
      wide <= i_wide_mode;
    end
  end
  assign o_width_select = wide;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: idle -> setup -> strobe/wait -> done -> idle
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state <= sram_host_pkg::ST_IDLE;
      wait_cnt <= 8'h00;
    end else begin
      case (state)
        sram_host_pkg::ST_IDLE: begin
          if (i_req_valid) begin
            state <= i_req_write ? sram_host_pkg::ST_WSET : sram_host_pkg::ST_RSET;
          end
        end
        // read setup cycle: data released before the gate opens
        sram_host_pkg::ST_RSET: begin
          state <= sram_host_pkg::ST_RWAIT;
          wait_cnt <= 8'(ACCESS_CYC + 2); // access plus synchroniser delay
        end
        sram_host_pkg::ST_RWAIT: begin
          if (wait_cnt == 8'h01) begin
            state <= sram_host_pkg::ST_DONE;
          end
          wait_cnt <= wait_cnt - 8'h01;
        end
        // write setup: address settles before the strobe; data is driven from the edge where the strobe falls
        sram_host_pkg::ST_WSET: begin
          state <= sram_host_pkg::ST_WPULSE;
          wait_cnt <= 8'(WRITE_CYC);
        end
        sram_host_pkg::ST_WPULSE: begin
          if (wait_cnt == 8'h01) begin
            state <= sram_host_pkg::ST_DONE;
          end
          wait_cnt <= wait_cnt - 8'h01;
        end
        // recovery cycle, strobe high and data still held
        sram_host_pkg::ST_DONE: begin
          state <= sram_host_pkg::ST_IDLE;
        end
        default: begin
          state <= sram_host_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request capture: address, lanes and data stay put for the access
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_mem_addr <= '0;
      is_write <= 1'b0;
      lanes <= 2'h0;
      wdata <= '0;
      x8_top <= 1'b0;
    end else if (o_req_ready && i_req_valid) begin
      is_write <= i_req_write;
      wdata <= i_req_wdata;
      if (wide) begin
        o_mem_addr <= i_req_addr[`SRAM_ADDR_W-1:0];
        lanes <= i_req_lanes;
        x8_top <= 1'b0;
      end else begin
        // x8: byte address, lowest bit onto top data pin
        o_mem_addr <= i_req_addr[`SRAM_BYTE_ADDR_W-1:1];
        x8_top <= i_req_addr[0];
        lanes <= 2'h3;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory control pins, all from flops
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_chip_select_low_n <= 1'b1;
      o_chip_select_high <= 1'b0;
      o_write_strobe_n <= 1'b1;
      o_output_gate_n <= 1'b1;
      o_low_lane_select_n <= 1'b1;
      o_high_lane_select_n <= 1'b1;
    end else begin
      case (state)
        // selects dropped outside accesses, lanes released too
        sram_host_pkg::ST_IDLE: begin
          o_chip_select_low_n <= !i_req_valid;
          o_chip_select_high <= i_req_valid;
          o_write_strobe_n <= 1'b1;
          o_output_gate_n <= 1'b1;
          o_low_lane_select_n <= 1'b1;
          o_high_lane_select_n <= 1'b1;
        end
        sram_host_pkg::ST_RSET: begin
          o_write_strobe_n <= 1'b1; // strobe held high for the read
          o_output_gate_n <= 1'b0;
          o_low_lane_select_n <= !(lanes[0] || !wide);
          o_high_lane_select_n <= !(lanes[1] || !wide);
        end
        sram_host_pkg::ST_WSET: begin
          o_write_strobe_n <= 1'b0;
          o_output_gate_n <= 1'b1;
          o_low_lane_select_n <= !(lanes[0] || !wide);
          o_high_lane_select_n <= !(lanes[1] || !wide);
        end
        sram_host_pkg::ST_WPULSE: begin
          if (wait_cnt == 8'h01) begin
            o_write_strobe_n <= 1'b1; // strobe rises before select drops
          end
        end
        sram_host_pkg::ST_RWAIT: begin
          if (wait_cnt == 8'h01) begin
            o_output_gate_n <= 1'b1;
          end
        end
        sram_host_pkg::ST_DONE: begin
          o_chip_select_low_n <= 1'b1;
          o_chip_select_high <= 1'b0;
          o_low_lane_select_n <= 1'b1;
          o_high_lane_select_n <= 1'b1;
        end
        default: begin
          o_chip_select_low_n <= 1'b1;
          o_chip_select_high <= 1'b0;
          o_write_strobe_n <= 1'b1;
          o_output_gate_n <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data pin drivers: write data only during write phases
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_data_pin <= '0;
      o_data_pin_oe <= '0;
    end else if (state == sram_host_pkg::ST_WSET || state == sram_host_pkg::ST_WPULSE) begin
      o_data_pin <= wdata;
      o_data_pin_oe <= wide ? {{8{lanes[1]}}, {8{lanes[0]}}} : 16'h80FF;
      if (!wide) begin
        o_data_pin[`SRAM_TOP_PIN] <= x8_top;
      end
    end else if (!wide && state != sram_host_pkg::ST_IDLE && state != sram_host_pkg::ST_DONE) begin
      // x8 read: only the address bit on the top pin is driven
      o_data_pin <= {x8_top, 15'h0000};
      o_data_pin_oe <= 16'h8000;
    end else begin
      o_data_pin_oe <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read answer, one-cycle pulse at end of read
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_resp_valid <= 1'b0;
      o_resp_rdata <= '0;
    end else begin
      o_resp_valid <= 1'b0;
      if (state == sram_host_pkg::ST_RWAIT && wait_cnt == 8'h01) begin
        o_resp_valid <= 1'b1;
        o_resp_rdata <= wide ? rdata_sync : {8'h00, rdata_sync[7:0]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  gate_off_write_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !o_write_strobe_n |-> o_output_gate_n) else $error("gate open during write");
  no_drive_read_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (!o_output_gate_n && wide) |-> (o_data_pin_oe == 16'h0000)) else $error("data driven in read");
  write_selected_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !o_write_strobe_n |-> (!o_chip_select_low_n && o_chip_select_high)) else $error("write unselected");
  read_selected_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !o_output_gate_n |-> (!o_chip_select_low_n && o_write_strobe_n)) else $error("read unselected");
  idle_standby_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (state == sram_host_pkg::ST_DONE) |=> o_chip_select_low_n && !o_chip_select_high) else $error("no standby");
  write_len_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    $fell(o_write_strobe_n) |-> !o_write_strobe_n [*2]) else $error("short write strobe");
  addr_stable_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (!o_chip_select_low_n && !$rose(o_chip_select_low_n) && !$past(o_chip_select_low_n)) |-> $stable(o_mem_addr))
    else $error("address moved");
  read_resp_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (state == sram_host_pkg::ST_RSET) |-> ##[1:10] o_resp_valid) else $error("no read answer");
  lanes_write_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (!o_write_strobe_n && wide) |-> (o_data_pin_oe[0] == !o_low_lane_select_n)) else $error("lane mismatch");
endmodule : sram_host

// file: sram_model.sv
`timescale 1ns/1ns
// behavioural memory device on the far side of the host pins
module sram_model (
  input wire logic [19:0] i_addr,
  input wire logic i_cs_low_n,
  input wire logic i_cs_high,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic i_lb_n,
  input wire logic i_ub_n,
  input wire logic i_width,
  input wire logic [15:0] i_pins,
  output logic [15:0] o_q,
  output logic [15:0] o_q_oe
);
  logic [15:0] mem16 [int]; // word store, any order
  logic [7:0] mem8 [int]; // byte store for the narrow path
  // standby when either select is off, or both lanes off in wide mode
  wire logic sel = !i_cs_low_n && i_cs_high && !(i_width && i_lb_n && i_ub_n);
  // narrow mode takes the top pin as the extra address bit
  wire logic [20:0] baddr = {i_pins[15], i_addr};
  ////////////////////////////////////////
  // the write lands as the strobe rises, while selects, lanes and data still stand;
  // capturing on the falling side would let pins still settling hit a wrong byte
  // the gate is not looked at
  always @(posedge i_we_n) begin
    if (sel) begin
      if (!i_width) mem8[baddr] = i_pins[7:0];
      else begin
        if (!i_lb_n) mem16[i_addr][7:0] = i_pins[7:0];
        if (!i_ub_n) mem16[i_addr][15:8] = i_pins[15:8]; // unselected lane kept
      end
    end
  end
  // drivers on only for a read with the gate low, otherwise released
  always @(*) begin
    o_q = 16'h0000;
    o_q_oe = 16'h0000;
    if (sel && i_we_n && !i_oe_n) begin
      if (!i_width) begin
        o_q = {8'h00, mem8[baddr]};
        o_q_oe = 16'h00FF; // byte pins only
      end else begin
        o_q = mem16[i_addr];
        o_q_oe = {{8{!i_ub_n}}, {8{!i_lb_n}}}; // per lane
      end
    end
  end
endmodule : sram_model

// file: testbench.sv
`timescale 1ns/1ns
module testbench;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_req_valid = 1'b0;
  logic i_req_write = 1'b0;
  logic [20:0] i_req_addr = 21'h000000;
  logic [15:0] i_req_wdata = 16'h0000;
  logic [1:0] i_req_lanes = 2'h3;
  logic i_wide_mode = 1'b1;
  logic o_req_ready, o_resp_valid, o_cs_n, o_cs, o_we_n, o_oe_n, o_lb_n, o_ub_n, o_width;
  logic [15:0] o_resp_rdata, o_data_pin, o_data_pin_oe, q, q_oe, pins;
  logic [19:0] o_mem_addr;
  logic tick = 1'b0; // released pins show a pattern that flips every cycle
  int n_errors = 0;
  int check_count = 0;
  logic [15:0] m16 [int]; // reference words
  logic [7:0] m8 [int]; // reference bytes
  ////////////////////////////////////////
  always #20 i_clock = ~i_clock;
  always @(posedge i_clock) tick <= ~tick;
  // wire level from both parties' enables
  assign pins = (o_data_pin & o_data_pin_oe) | (q & q_oe & ~o_data_pin_oe) | ({16{tick}} & ~o_data_pin_oe & ~q_oe);
  sram_host sram_host_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_req_valid(i_req_valid),
    .o_req_ready(o_req_ready), .i_req_write(i_req_write), .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata),
    .i_req_lanes(i_req_lanes), .i_wide_mode(i_wide_mode), .o_resp_valid(o_resp_valid),
    .o_resp_rdata(o_resp_rdata), .o_mem_addr(o_mem_addr), .o_chip_select_low_n(o_cs_n),
    .o_chip_select_high(o_cs), .o_write_strobe_n(o_we_n), .o_output_gate_n(o_oe_n),
    .o_low_lane_select_n(o_lb_n), .o_high_lane_select_n(o_ub_n), .o_width_select(o_width),
    .i_data_pin(pins), .o_data_pin(o_data_pin), .o_data_pin_oe(o_data_pin_oe));
  sram_model sram_model_i (.i_addr(o_mem_addr), .i_cs_low_n(o_cs_n), .i_cs_high(o_cs), .i_we_n(o_we_n),
    .i_oe_n(o_oe_n), .i_lb_n(o_lb_n), .i_ub_n(o_ub_n), .i_width(o_width), .i_pins(pins), .o_q(q), .o_q_oe(q_oe));
  ////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("counts: checks=%0d mismatches=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  // two parties never drive one pin together
  always @(posedge i_clock) if ((o_data_pin_oe & q_oe) != 16'h0000) check(o_data_pin_oe & q_oe, 16'h0000);
  // idle pins: deselected, strobes high, host released, width pin as chosen
  task automatic idle_check(input logic w);
    check({9'h000, o_cs_n, o_cs, o_we_n, o_oe_n, o_lb_n, o_ub_n, o_width}, {9'h000, 6'h2F, w});
    check(o_data_pin_oe, 16'h0000);
  endtask : idle_check
  // bounded wait on a design flag; a timeout closes the run
  task automatic wait_flag(input bit rdy);
    int i;
    for (i = 0; i < 50 && (rdy ? o_req_ready : o_resp_valid) !== 1'b1; i++) @(posedge i_clock) #1;
    if ((rdy ? o_req_ready : o_resp_valid) !== 1'b1) begin
      n_errors++;
      summarize();
    end
  endtask : wait_flag
  // one request held until taken; reads compared with the reference
  task automatic access(input logic wr, input logic [20:0] a, input logic [15:0] d, input logic [1:0] ln);
    wait_flag(1'b1);
    i_req_valid = 1'b1;
    i_req_write = wr;
    i_req_addr = a;
    i_req_wdata = d;
    i_req_lanes = ln;
    @(posedge i_clock) #1;
    i_req_valid = 1'b0;
    if (wr && !i_wide_mode) m8[a] = d[7:0];
    else if (wr) begin
      if (ln[0]) m16[a[19:0]][7:0] = d[7:0];
      if (ln[1]) m16[a[19:0]][15:8] = d[15:8];
    end else begin
      wait_flag(1'b0);
      if (i_wide_mode) check(o_resp_rdata, m16[a[19:0]]);
      else check(o_resp_rdata, {8'h00, m8[a]});
    end
  endtask : access
  ////////////////////////////////////////
  initial begin
    logic [20:0] a [$];
    logic [20:0] b;
    void'($urandom(32'hE1AC));
    repeat (4) @(posedge i_clock);
    #1 i_sys_rst = 1'b0;
    idle_check(1'b1);
    // wide path: boundaries and random words, then every lane mix, read back
    a = {21'h000000, 21'h0FFFFF};
    repeat (6) a.push_back(21'($urandom) & 21'h0FFFFF);
    foreach (a[j]) access(1'b1, a[j], 16'($urandom), 2'h3);
    foreach (a[j]) access(1'b1, a[j], 16'($urandom), 2'(j % 3 + 1));
    foreach (a[j]) access(1'b0, a[j], 16'h0000, 2'h3);
    wait_flag(1'b1);
    idle_check(1'b1);
    $display("test wide path done");
    // reset in mid-run leaves pins idle, memory keeps its contents
    i_sys_rst = 1'b1;
    repeat (2) @(posedge i_clock) #1;
    i_sys_rst = 1'b0;
    idle_check(1'b1);
    access(1'b0, a[1], 16'h0000, 2'h3);
    $display("test reset done");
    // narrow path: byte pairs differing only in the top-pin address bit
    // width changed only while idle, then one quiet cycle for it to settle
    i_wide_mode = 1'b0;
    wait_flag(1'b1);
    @(posedge i_clock) #1;
    a = {21'h000000, 21'h1FFFFF};
    repeat (4) begin
      b = 21'($urandom);
      a.push_back(b);
      a.push_back(b ^ 21'h000001);
    end
    foreach (a[j]) access(1'b1, a[j], 16'($urandom), 2'($urandom));
    foreach (a[j]) access(1'b0, a[j], 16'h0000, 2'($urandom));
    wait_flag(1'b1);
    idle_check(1'b0);
    $display("test narrow path done");
    summarize();
  end
endmodule : testbench
